// file: hw/zsle_encoder.sv
// Transmit line encoder: B3ZS/HDB3 zero substitution onto bipolar rails
// Summary of operation
// [R1] DS3 with rails enabled uses three-zero substitution
// [R2] Three zeros become 00V or B0V
// [R3] Pick pattern so B count between Vs odd
// [R4] E3 modes with rails use four-zero substitution
// [R5] Four zeros become 000V or B00V
// [R6] Pick pattern so B count between Vs odd
// [R7] B alternates polarity; V repeats last polarity
// [R8] Rails disabled: plain NRZ, no substitution
`timescale 1ns/1ps
module zsle_encoder (
	// Clock, reset and enable
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	// Configuration from the framer core
	input wire zsle_pkg::zsle_mode_t mode_i,
	input wire logic rail_en_i,
	// Framed bit stream in
	input wire logic bit_i,
	input wire logic bit_valid_i,
	output logic bit_ready_o,
	// Line side: one symbol per line tick while the FIFO holds a bit
	input wire logic line_tick_i,
	output zsle_pkg::zsle_line_t line_o
);

	typedef struct packed {
		zsle_pkg::zsle_sym_t [zsle_pkg::WIN_LEN-1:0] win;
		logic last_pol;
		logic par;
		logic fresh;
		zsle_pkg::zsle_sym_t out_kind;
		zsle_pkg::zsle_line_t line;
	} zsle_enc_state_t;

	zsle_enc_state_t st_r;
	zsle_enc_state_t st_nxt;
	logic fifo_vld;
	logic fifo_bit;
	logic pop;

	// Last window slot for the current mode, used by encoder and checks
	function automatic logic [1:0] zsle_last_slot(input zsle_pkg::zsle_mode_t m);
		zsle_last_slot = (m == zsle_pkg::ZSLE_MODE_DS3) ? zsle_pkg::B3ZS_LAST :
			zsle_pkg::HDB3_LAST;
	endfunction : zsle_last_slot

	// True for marks that obey the alternation rule
	function automatic logic zsle_is_b(input zsle_pkg::zsle_sym_t k);
		zsle_is_b = (k == zsle_pkg::ZSLE_SYM_ONE) || (k == zsle_pkg::ZSLE_SYM_BSUB);
	endfunction : zsle_is_b

	////////////////////////////////////////////////////////////////////////////////
	// Input buffer; the line tick drains it so a slow line back-pressures the framer
	zsle_fifo #(
		.W(zsle_pkg::FIFO_WIDTH),
		.D(zsle_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.in_valid_i(bit_valid_i),
		.in_ready_o(bit_ready_o),
		.in_data_i(bit_i),
		.out_valid_o(fifo_vld),
		.out_ready_i(line_tick_i),
		.out_data_o(fifo_bit)
	);

	assign pop = fifo_vld && line_tick_i;

	////////////////////////////////////////////////////////////////////////////////
	// Look-ahead window; substitution is decided when the newest run of zeros fills it
	always_comb begin
		logic [1:0] last;
		zsle_pkg::zsle_sym_t outgoing;
		zsle_pkg::zsle_sym_t [zsle_pkg::WIN_LEN-1:0] shifted;
		logic par_now;
		logic allz;
		logic mark;
		logic pol;
		last = zsle_last_slot(mode_i);
		outgoing = st_r.win[last];
		shifted[zsle_pkg::WIN_LEN-1:1] = st_r.win[zsle_pkg::WIN_LEN-2:0];
		shifted[0] = fifo_bit ? zsle_pkg::ZSLE_SYM_ONE : zsle_pkg::ZSLE_SYM_ZERO;
		// Parity counts the symbol leaving now, since nothing ahead of the run is a mark
		par_now = (outgoing == zsle_pkg::ZSLE_SYM_VIOL) ? 1'b0 :
			(st_r.par ^ zsle_is_b(outgoing));
		allz = 1'b1;
		mark = 1'b0;
		pol = 1'b0;
		// [R2] [R5] reset fill coded
		// The idle fill is already a full zero run; code it as it leaves, or a bare run goes out
		if (st_r.fresh && rail_en_i) begin
			if (!st_r.par) begin
				outgoing = zsle_pkg::ZSLE_SYM_BSUB;
				par_now = 1'b1;
			end
			shifted[1] = zsle_pkg::ZSLE_SYM_VIOL;
		end
		st_nxt = st_r;
		st_nxt.line = '0;
		for (int i = 0; i < zsle_pkg::WIN_LEN; i++) begin
			if ((i <= int'(last)) && (shifted[i] != zsle_pkg::ZSLE_SYM_ZERO)) begin
				allz = 1'b0;
			end
		end
		if (pop) begin
			// [R1] [R4] code chosen by mode
			// [R2] [R5] run becomes V pattern
			// [R3] [R6] B keeps count odd
			if (rail_en_i && allz) begin
				shifted[0] = zsle_pkg::ZSLE_SYM_VIOL;
				if (!par_now) begin
					shifted[last] = zsle_pkg::ZSLE_SYM_BSUB;
				end
			end
			st_nxt.win = shifted;
			st_nxt.fresh = 1'b0;
			st_nxt.par = par_now;
			st_nxt.out_kind = outgoing;
			st_nxt.line.vld = 1'b1;
			if (rail_en_i) begin
				// [R7] V repeats, B alternates
				mark = (outgoing != zsle_pkg::ZSLE_SYM_ZERO);
				pol = (outgoing == zsle_pkg::ZSLE_SYM_VIOL) ? st_r.last_pol : !st_r.last_pol;
				st_nxt.line.pos = mark && pol;
				st_nxt.line.neg = mark && !pol;
				if (mark) begin
					st_nxt.last_pol = pol;
				end
			end else begin
				// [R8] NRZ pass-through
				st_nxt.line.nrz = (outgoing != zsle_pkg::ZSLE_SYM_ZERO);
			end
		end
	end

	// State register; the window starts as idle zeros
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r <= '0;
			st_r.last_pol <= zsle_pkg::RST_LAST_POL;
			st_r.par <= zsle_pkg::RST_PAR;
			st_r.fresh <= 1'b1;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	assign line_o = st_r.line;

	////////////////////////////////////////////////////////////////////////////////
	// Check history: what went out before the symbol now on the line
	logic h_pol;
	logic h_odd;
	logic h_seen_v;
	zsle_pkg::zsle_sym_t h_k1;
	zsle_pkg::zsle_sym_t h_k2;
	logic [2:0] h_zrun;
	logic [3:0] h_settle;
	zsle_pkg::zsle_mode_t h_mode;
	logic h_rail;
	logic settled;
	logic ev;

	assign ev = st_r.line.vld;
	// Mode switches reshape the window, so checks wait for it to refill
	assign settled = (h_settle >= 4'h8) && (h_mode == mode_i) && (h_rail == rail_en_i);

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			h_pol <= zsle_pkg::RST_LAST_POL;
			h_odd <= 1'b0;
			h_seen_v <= 1'b0;
			h_k1 <= zsle_pkg::ZSLE_SYM_ZERO;
			h_k2 <= zsle_pkg::ZSLE_SYM_ZERO;
			h_zrun <= 3'h0;
			h_settle <= 4'h0;
			h_mode <= zsle_pkg::ZSLE_MODE_DS3;
			h_rail <= 1'b0;
		end else if (ce_i) begin
			h_mode <= mode_i;
			h_rail <= rail_en_i;
			if ((h_mode != mode_i) || (h_rail != rail_en_i)) begin
				h_settle <= 4'h0;
				h_seen_v <= 1'b0;
			end else if (ev && (h_settle != 4'hf)) begin
				h_settle <= h_settle + 4'h1;
			end
			if (ev) begin
				h_k1 <= st_r.out_kind;
				h_k2 <= h_k1;
				h_zrun <= (st_r.out_kind == zsle_pkg::ZSLE_SYM_ZERO) ? h_zrun + 3'h1 : 3'h0;
				if (st_r.line.pos || st_r.line.neg) begin
					h_pol <= st_r.line.pos;
				end
				if (st_r.out_kind == zsle_pkg::ZSLE_SYM_VIOL) begin
					h_odd <= 1'b0;
					h_seen_v <= 1'b1;
				end else if (zsle_is_b(st_r.out_kind)) begin
					h_odd <= !h_odd;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	a_rail_exclusive: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R7]
		!(line_o.pos && line_o.neg))
		else $error("both rails driven at once");

	a_nrz_no_rails: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R8]
		(ev && !h_rail && settled) |-> (!line_o.pos && !line_o.neg
			&& st_r.out_kind inside {zsle_pkg::ZSLE_SYM_ZERO, zsle_pkg::ZSLE_SYM_ONE}))
		else $error("rails or substitution seen in NRZ mode");

	a_zero_run_cap: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R2]
		(ev && h_rail && settled && st_r.out_kind == zsle_pkg::ZSLE_SYM_ZERO)
			|-> (h_zrun < 3'(zsle_last_slot(mode_i))))
		else $error("zero run reached substitution length");

	a_viol_repeat: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R7]
		(ev && h_rail && st_r.out_kind == zsle_pkg::ZSLE_SYM_VIOL)
			|-> (line_o.pos == h_pol) && (line_o.neg == !h_pol))
		else $error("violation did not repeat last polarity");

	a_b_alternate: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R7]
		(ev && h_rail && zsle_is_b(st_r.out_kind)) |-> (line_o.pos == !h_pol))
		else $error("bipolar mark did not alternate");

	a_odd_b_count: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R3]
		(ev && settled && h_seen_v && st_r.out_kind == zsle_pkg::ZSLE_SYM_VIOL) |-> h_odd)
		else $error("even number of B pulses between violations");

	a_b3zs_shape: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R1]
		(ev && settled && h_rail && mode_i == zsle_pkg::ZSLE_MODE_DS3
			&& st_r.out_kind == zsle_pkg::ZSLE_SYM_VIOL)
			|-> (h_k1 == zsle_pkg::ZSLE_SYM_ZERO)
			&& (h_k2 inside {zsle_pkg::ZSLE_SYM_ZERO, zsle_pkg::ZSLE_SYM_BSUB}))
		else $error("three-zero substitution pattern malformed");

	a_hdb3_shape: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R5]
		(ev && settled && h_rail && mode_i != zsle_pkg::ZSLE_MODE_DS3
			&& st_r.out_kind == zsle_pkg::ZSLE_SYM_VIOL)
			|-> (h_k1 == zsle_pkg::ZSLE_SYM_ZERO) && (h_k2 == zsle_pkg::ZSLE_SYM_ZERO))
		else $error("four-zero substitution pattern malformed");

	a_bsub_leads: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R5]
		(ce_i && settled && h_rail && st_r.line.vld && st_r.out_kind == zsle_pkg::ZSLE_SYM_BSUB
			&& mode_i != zsle_pkg::ZSLE_MODE_DS3)
			|-> (!ce_i || !pop || st_nxt.out_kind == zsle_pkg::ZSLE_SYM_ZERO))
		else $error("inserted B not followed by a zero");

	a_tick_paced: assert property (@(posedge mclk_i) disable iff (!resetn_i) // one symbol per line tick
		(ce_i && !line_tick_i) |=> !line_o.vld)
		else $error("symbol emitted without a line tick");

	c_ds3_viol: cover property (@(posedge mclk_i) disable iff (!resetn_i)
		ev && h_rail && mode_i == zsle_pkg::ZSLE_MODE_DS3
			&& st_r.out_kind == zsle_pkg::ZSLE_SYM_VIOL);
	c_e3_bsub: cover property (@(posedge mclk_i) disable iff (!resetn_i)
		ev && h_rail && mode_i != zsle_pkg::ZSLE_MODE_DS3
			&& st_r.out_kind == zsle_pkg::ZSLE_SYM_BSUB);
	c_nrz_one: cover property (@(posedge mclk_i) disable iff (!resetn_i)
		ev && !h_rail && line_o.nrz);
	c_fifo_full: cover property (@(posedge mclk_i) disable iff (!resetn_i)
		bit_valid_i && !bit_ready_o);

endmodule : zsle_encoder

// file: hw/zsle_pkg.sv
// Shared constants and types of the zero substitution line encoder
package zsle_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Sizes and run lengths
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 1;
	localparam int WIN_LEN = 4;
	// Last slot of the look-ahead window for each code (run length minus one)
	localparam logic [1:0] B3ZS_LAST = 2'h2;
	localparam logic [1:0] HDB3_LAST = 2'h3;
	// Reset polarity of the last mark: low, so the first mark goes out positive
	localparam logic RST_LAST_POL = 1'b0;
	localparam logic RST_PAR = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Framing modes and symbol kinds
	typedef enum logic [1:0] {
		ZSLE_MODE_DS3,
		ZSLE_MODE_G751,
		ZSLE_MODE_G832
	} zsle_mode_t;

	typedef enum logic [1:0] {
		ZSLE_SYM_ZERO,
		ZSLE_SYM_ONE,
		ZSLE_SYM_BSUB,
		ZSLE_SYM_VIOL
	} zsle_sym_t;

	// One line symbol towards the line interface unit
	typedef struct packed {
		logic pos;
		logic neg;
		logic nrz;
		logic vld;
	} zsle_line_t;

endpackage : zsle_pkg

// file: hw/zsle_fifo.sv
// Parameterised valid/ready FIFO in the encoder's data path
`timescale 1ns/1ps
module zsle_fifo #(
	parameter int W = 1,
	parameter int D = 16
) (
	// Clock, reset and enable
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	// Filling side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// Draining side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);

	localparam int AW = (D > 1) ? $clog2(D) : 1;

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic nfull;
		logic nempty;
	} zsle_fifo_state_t;

	zsle_fifo_state_t st_r;
	zsle_fifo_state_t st_nxt;
	logic push;
	logic pop;

	////////////////////////////////////////////////////////////////////////////////
	// Pointer and flag update; flags are registered so ready and valid come from flops
	always_comb begin
		st_nxt = st_r;
		push = in_valid_i && st_r.nfull;
		pop = out_ready_i && st_r.nempty;
		if (push) begin
			st_nxt.mem[st_r.wp] = in_data_i;
			st_nxt.wp = (st_r.wp == AW'(D - 1)) ? '0 : st_r.wp + 1'b1;
		end
		if (pop) begin
			st_nxt.rp = (st_r.rp == AW'(D - 1)) ? '0 : st_r.rp + 1'b1;
		end
		if (push && !pop) begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end else if (pop && !push) begin
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
		st_nxt.nfull = (st_nxt.cnt != (AW+1)'(D));
		st_nxt.nempty = (st_nxt.cnt != '0);
	end

	// State register; enable low freezes everything
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r <= '0;
			st_r.nfull <= 1'b1;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	assign in_ready_o = st_r.nfull;
	assign out_valid_o = st_r.nempty;
	assign out_data_o = st_r.mem[st_r.rp];

endmodule : zsle_fifo

// file: tb/zsle_liu_model.sv
// Line interface unit model: paces line ticks and records every symbol
`timescale 1ns/1ps
module zsle_liu_model (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Pacing control
	input wire logic en_i,
	input wire logic slow_i,
	// Encoder line side
	input wire zsle_pkg::zsle_line_t line_i,
	output logic line_tick_o
);
	logic [2:0] sym_q[$];
	logic odd_r;

	////////////////////////////////////////////////////////////////////////////////
	// Slow pacing stalls every other cycle so the FIFO backs up
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			odd_r <= 1'b0;
			line_tick_o <= 1'b0;
		end else begin
			odd_r <= ~odd_r;
			line_tick_o <= en_i && (!slow_i || odd_r);
		end
	end

	// Take a symbol only in the one cycle its valid pulse stands
	always @(posedge mclk_i) begin
		if (resetn_i && line_i.vld === 1'b1) begin
			sym_q.push_back({line_i.pos, line_i.neg, line_i.nrz});
		end
	end
endmodule : zsle_liu_model

// file: tb/tb_zsle_encoder.sv
// Self-checking bench for the zero substitution line encoder
`timescale 1ns/1ps
module tb_zsle_encoder;
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	zsle_pkg::zsle_mode_t mode_i = zsle_pkg::ZSLE_MODE_DS3;
	logic rail_en_i = 1'b1;
	logic bit_i = 1'b0;
	logic bit_valid_i = 1'b0;
	logic bit_ready_o;
	logic line_tick_i;
	zsle_pkg::zsle_line_t line_o;
	logic en = 1'b0;
	logic slow = 1'b0;
	int fail_count = 0;
	int checks = 0;
	int cyc = 0;

	always #5 mclk_i = ~mclk_i;

	zsle_encoder zsle_encoder_inst (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(1'b1), .mode_i(mode_i),
		.rail_en_i(rail_en_i), .bit_i(bit_i), .bit_valid_i(bit_valid_i),
		.bit_ready_o(bit_ready_o), .line_tick_i(line_tick_i), .line_o(line_o));

	zsle_liu_model zsle_liu_model_inst (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .en_i(en), .slow_i(slow),
		.line_i(line_o), .line_tick_o(line_tick_i));

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and hang guard
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out

	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			close_out();
		end
	end

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : check

	////////////////////////////////////////////////////////////////////////////////
	// Fill the FIFO with the line paused, drain it, compare against a reference coder
	task automatic run(input string nm, input zsle_pkg::zsle_mode_t m, input logic rail,
			input logic [15:0] pat, input logic sl);
		logic s[$];
		int kd[$];
		int k;
		int ln;
		int cnt;
		int z;
		logic pol;
		logic [2:0] e;
		ln = (m == zsle_pkg::ZSLE_MODE_DS3) ? 3 : 4;
		mode_i = m;
		rail_en_i = rail;
		slow = sl;
		en = 1'b0;
		resetn_i = 1'b0;
		repeat (8) @(posedge mclk_i);
		#1 resetn_i = 1'b1;
		zsle_liu_model_inst.sym_q.delete();
		check("ready after reset", 8'h01, {7'h00, bit_ready_o});
		for (int i = 15; i >= 0; i--) begin
			bit_i = pat[i];
			bit_valid_i = 1'b1;
			@(posedge mclk_i);
			#1;
		end
		check("ready when full", 8'h00, {7'h00, bit_ready_o});
		// An extra bit offered while full must be ignored; a zero would show on the lead one
		bit_i = 1'b0;
		repeat (4) @(posedge mclk_i);
		#1 bit_valid_i = 1'b0;
		en = 1'b1;
		for (int i = 0; i < 200 && zsle_liu_model_inst.sym_q.size() < 16; i++) begin
			@(posedge mclk_i);
		end
		repeat (10) @(posedge mclk_i);
		#1 en = 1'b0;
		check("symbol count", 8'h10, 8'(zsle_liu_model_inst.sym_q.size()));
		if (zsle_liu_model_inst.sym_q.size() < 16) begin
			return;
		end
		// Reference: reset window zeros lead, marks since last violation start even
		for (int i = 0; i < ln; i++) begin
			s.push_back(1'b0);
		end
		for (int i = 15; i >= 0; i--) begin
			s.push_back(pat[i]);
		end
		k = 0;
		cnt = 0;
		while (k < s.size()) begin
			z = (k + ln <= s.size());
			for (int j = 0; j < ln && z != 0; j++) begin
				if (s[k + j]) begin
					z = 0;
				end
			end
			if (rail && z != 0) begin
				kd.push_back(cnt[0] ? 0 : 2);
				repeat (ln - 2) kd.push_back(0);
				kd.push_back(3);
				cnt = 0;
				k += ln;
			end else begin
				kd.push_back(int'(s[k]));
				cnt += int'(s[k]);
				k++;
			end
		end
		// First mark goes out positive; violations repeat the last mark
		pol = 1'b0;
		for (int i = 0; i < 16; i++) begin
			if (kd[i] == 1 || kd[i] == 2) begin
				pol = ~pol;
			end
			if (!rail) begin
				e = {2'b00, s[i]};
			end else if (kd[i] == 0) begin
				e = 3'h0;
			end else begin
				e = {pol, ~pol, 1'b0};
			end
			check("symbol", {5'h00, e}, {5'h00, zsle_liu_model_inst.sym_q[i]});
		end
		$display("test %s done", nm);
	endtask : run

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_ds3();
		run("ds3 rails", zsle_pkg::ZSLE_MODE_DS3, 1'b1, 16'h8d00, 1'b0);
	endtask : t_ds3

	task automatic t_g751();
		run("g751 rails", zsle_pkg::ZSLE_MODE_G751, 1'b1, 16'h9008, 1'b1);
	endtask : t_g751

	task automatic t_g832();
		run("g832 rails", zsle_pkg::ZSLE_MODE_G832, 1'b1, 16'h8f00, 1'b1);
	endtask : t_g832

	task automatic t_nrz();
		run("nrz", zsle_pkg::ZSLE_MODE_DS3, 1'b0, 16'h8d00, 1'b0);
	endtask : t_nrz

	initial begin
		t_ds3();
		t_g751();
		t_g832();
		t_nrz();
		close_out();
	end
endmodule : tb_zsle_encoder
